// File: fsr_pkg.sv
// Shared constants and carrier types for the fault status register bank
package fsr_pkg;

    localparam int          FSR_NUM_CHAN       = 4;
    localparam int          FSR_ADDR_W         = 4;
    localparam int          FSR_DATA_W         = 8;

    // Register offsets
    localparam logic [3:0]  FSR_OFS_CHAN_SUM   = 4'h1;
    localparam logic [3:0]  FSR_OFS_GLOBAL     = 4'h2;
    localparam logic [3:0]  FSR_OFS_SHORT      = 4'h3;
    localparam logic [3:0]  FSR_OFS_OPEN_OFF   = 4'h4;

    // Values after reset
    localparam logic [7:0]  FSR_RST_GLOBAL     = 8'h47;
    localparam logic [7:0]  FSR_RST_SHORT      = 8'h00;
    localparam logic [7:0]  FSR_RST_OPEN_OFF   = 8'h00;
    localparam logic [7:0]  FSR_RST_CHAN_SUM   = 8'h00;
    localparam logic [7:0]  FSR_UNMAPPED_DATA  = 8'h00;

    // Global fault kinds field positions
    localparam int          FSR_BIT_POWER_ON   = 6;
    localparam int          FSR_BIT_DIE_OT     = 5;
    localparam int          FSR_BIT_LINK_ERR   = 4;
    localparam int          FSR_BIT_LINK_WDT   = 3;
    localparam int          FSR_BIT_LOGIC_UV   = 2;
    localparam int          FSR_BIT_LOAD_WARN  = 1;
    localparam int          FSR_BIT_LOAD_UV    = 0;
    localparam int          FSR_GLOBAL_W       = 7;

    // Live per-channel fault conditions, bit n is channel n+1
    typedef struct packed {
        logic [3:0] reverse_block_fault;
        logic [3:0] channel_overtemp_fault;
        logic [3:0] current_limit_fault;
        logic [3:0] open_wire_on_fault;
        logic [3:0] open_wire_off_fault;
        logic [3:0] short_to_supply_fault;
    } fsr_chan_cond_t;

    // Live device-wide fault conditions
    typedef struct packed {
        logic die_overtemp;
        logic link_frame_error;
        logic link_watchdog_expired;
        logic logic_supply_low;
        logic load_supply_warn;
        logic load_supply_low;
    } fsr_global_cond_t;

endpackage : fsr_pkg

// File: fsr_rc_latch.sv
// Bank of sticky flags that clear on read only once their condition is gone
`timescale 1ns/1ps
module fsr_rc_latch
    import fsr_pkg::*;
#(
    parameter int              WIDTH     = 4,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
)
(
    // Clock and reset
    input  wire logic             mclk_i,
    input  wire logic             reset_n_i,
    // Conditions and read strobe
    input  wire logic [WIDTH-1:0] cond_i,
    input  wire logic             rd_clr_i,
    // Latched flags
    output logic      [WIDTH-1:0] flag_o
);

    logic [WIDTH-1:0] flag_q;
    logic [WIDTH-1:0] flag_d;

    // A live condition always wins over the read clear
    always_comb
    begin
        flag_d = cond_i | (flag_q & {WIDTH{~rd_clr_i}});
    end

    always_ff @(posedge mclk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            flag_q <= RESET_VAL;
        else
            flag_q <= flag_d;
    end

    assign flag_o = flag_q;

endmodule : fsr_rc_latch

// File: fsr_fault_status.sv
// Fault status register bank: global kinds, short-to-supply, open wire, summary
`timescale 1ns/1ps
// How it works
// - Channel one summary bit reports any fault
// - Global kinds at offset 2, reset 47h
// - Power-on flag bit 6, cleared by read
// - Die overtemperature bit 5, read clears when gone
// - Link error bit 4 latched, read clears when gone
// - Watchdog timeout bit 3 latched, read clears when gone
// - Logic supply lockout bit 2, reset one
// - Load supply warning bit 1, reset one
// - Load supply low bit 0, reset one
// - Short-to-supply at offset 3, four channel flags
// - Open wire at offset 4, channels one-four
// - Summary at offset 1, OR per channel
// - Open wire bit 0 is channel one
module fsr_fault_status
    import fsr_pkg::*;
#(
    parameter int NUM_CHAN = FSR_NUM_CHAN
)
(
    // Clock and reset
    input  wire logic                  mclk_i,
    input  wire logic                  reset_n_i,
    // Fault conditions from the analog side
    input  wire fsr_chan_cond_t        chan_cond_i,
    input  wire fsr_global_cond_t      global_cond_i,
    // Register read port
    input  wire logic                  rd_req_i,
    input  wire logic [FSR_ADDR_W-1:0] rd_addr_i,
    output logic      [FSR_DATA_W-1:0] rd_data_o,
    output logic                       rd_valid_o,
    // Latched flags for the rest of the device
    output logic      [FSR_DATA_W-1:0] chan_fault_summary_o
);

    logic [FSR_GLOBAL_W-1:0] global_q;
    logic [NUM_CHAN-1:0]     short_q;
    logic [NUM_CHAN-1:0]     open_q;
    logic [FSR_GLOBAL_W-1:0] global_cond;
    logic                    rd_global;
    logic                    rd_short;
    logic                    rd_open;
    logic [NUM_CHAN-1:0]     summary_src;
    logic [FSR_DATA_W-1:0]   summary_d;
    logic [FSR_DATA_W-1:0]   summary_q;
    logic [FSR_DATA_W-1:0]   rd_data_d;
    logic [FSR_DATA_W-1:0]   rd_data_q;
    logic                    rd_valid_q;

    // Request and address are arguments so a continuous assign stays sensitive to them
    function automatic logic hit(input logic                  req,
                                 input logic [FSR_ADDR_W-1:0] addr,
                                 input logic [FSR_ADDR_W-1:0] ofs);
        hit = req && (addr == ofs);
    endfunction : hit

    function automatic logic [FSR_DATA_W-1:0] pad(input logic [NUM_CHAN-1:0] v);
        pad = FSR_DATA_W'(v);
    endfunction : pad

    assign rd_global = hit(rd_req_i, rd_addr_i, FSR_OFS_GLOBAL);
    assign rd_short  = hit(rd_req_i, rd_addr_i, FSR_OFS_SHORT);
    assign rd_open   = hit(rd_req_i, rd_addr_i, FSR_OFS_OPEN_OFF);

    // Power-on has no live condition, so any read of offset 2 clears it
    always_comb
    begin
        global_cond                    = '0;
        global_cond[FSR_BIT_POWER_ON]  = 1'b0;
        global_cond[FSR_BIT_DIE_OT]    = global_cond_i.die_overtemp;
        global_cond[FSR_BIT_LINK_ERR]  = global_cond_i.link_frame_error;
        global_cond[FSR_BIT_LINK_WDT]  = global_cond_i.link_watchdog_expired;
        global_cond[FSR_BIT_LOGIC_UV]  = global_cond_i.logic_supply_low;
        global_cond[FSR_BIT_LOAD_WARN] = global_cond_i.load_supply_warn;
        global_cond[FSR_BIT_LOAD_UV]   = global_cond_i.load_supply_low;
    end

    // Global kinds, reset 47h
    fsr_rc_latch #(
        .WIDTH     (FSR_GLOBAL_W),
        .RESET_VAL (FSR_RST_GLOBAL[FSR_GLOBAL_W-1:0])
    ) u_global (
        .mclk_i    (mclk_i),
        .reset_n_i (reset_n_i),
        .cond_i    (global_cond),
        .rd_clr_i  (rd_global),
        .flag_o    (global_q)
    );

    // Short-to-supply, clear only when fault gone
    fsr_rc_latch #(
        .WIDTH     (NUM_CHAN),
        .RESET_VAL (FSR_RST_SHORT[NUM_CHAN-1:0])
    ) u_short (
        .mclk_i    (mclk_i),
        .reset_n_i (reset_n_i),
        .cond_i    (chan_cond_i.short_to_supply_fault[NUM_CHAN-1:0]),
        .rd_clr_i  (rd_short),
        .flag_o    (short_q)
    );

    // Off-state open wire, bit 0 is channel one
    fsr_rc_latch #(
        .WIDTH     (NUM_CHAN),
        .RESET_VAL (FSR_RST_OPEN_OFF[NUM_CHAN-1:0])
    ) u_open (
        .mclk_i    (mclk_i),
        .reset_n_i (reset_n_i),
        .cond_i    (chan_cond_i.open_wire_off_fault[NUM_CHAN-1:0]),
        .rd_clr_i  (rd_open),
        .flag_o    (open_q)
    );

    // Summary: the other fault kinds are latched elsewhere, so their live
    // conditions stand in for them here
    always_comb
    begin
        summary_src = short_q | open_q
                    | chan_cond_i.reverse_block_fault[NUM_CHAN-1:0]
                    | chan_cond_i.channel_overtemp_fault[NUM_CHAN-1:0]
                    | chan_cond_i.current_limit_fault[NUM_CHAN-1:0]
                    | chan_cond_i.open_wire_on_fault[NUM_CHAN-1:0]
                    | chan_cond_i.open_wire_off_fault[NUM_CHAN-1:0]
                    | chan_cond_i.short_to_supply_fault[NUM_CHAN-1:0];
        summary_d   = pad(summary_src);
    end

    // Read mux samples flags before the read clear lands
    always_comb
    begin
        case (rd_addr_i)
            FSR_OFS_CHAN_SUM: rd_data_d = summary_q;
            FSR_OFS_GLOBAL:   rd_data_d = {1'b0, global_q};
            FSR_OFS_SHORT:    rd_data_d = pad(short_q);
            FSR_OFS_OPEN_OFF: rd_data_d = pad(open_q);
            default:          rd_data_d = FSR_UNMAPPED_DATA;
        endcase
        if (!rd_req_i)
            rd_data_d = rd_data_q;
    end

    always_ff @(posedge mclk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            summary_q  <= FSR_RST_CHAN_SUM;
            rd_data_q  <= FSR_UNMAPPED_DATA;
            rd_valid_q <= 1'b0;
        end
        else
        begin
            summary_q  <= summary_d;
            rd_data_q  <= rd_data_d;
            rd_valid_q <= rd_req_i;
        end
    end

    assign rd_data_o            = rd_data_q;
    assign rd_valid_o           = rd_valid_q;
    assign chan_fault_summary_o = summary_q;

    // Assertions
    sequence s_global_read;
        rd_req_i && rd_addr_i == FSR_OFS_GLOBAL;
    endsequence

    sequence s_chan1_clean;
        !short_q[0] && !open_q[0] && !chan_cond_i.reverse_block_fault[0]
        && !chan_cond_i.channel_overtemp_fault[0]
        && !chan_cond_i.current_limit_fault[0]
        && !chan_cond_i.open_wire_on_fault[0]
        && !chan_cond_i.open_wire_off_fault[0]
        && !chan_cond_i.short_to_supply_fault[0];
    endsequence

    sequence s_chan1_fault;
        chan_cond_i.reverse_block_fault[0] || chan_cond_i.channel_overtemp_fault[0]
        || chan_cond_i.current_limit_fault[0] || chan_cond_i.open_wire_on_fault[0]
        || chan_cond_i.open_wire_off_fault[0] || chan_cond_i.short_to_supply_fault[0]
        || short_q[0] || open_q[0];
    endsequence

    property p_chan1_set;
        @(posedge mclk_i) disable iff (!reset_n_i)
        s_chan1_fault |=> summary_q[0];
    endproperty
    a_chan1_set: assert property (p_chan1_set)
        else $error("summary bit 0 missed fault");

    property p_global_top_zero;
        @(posedge mclk_i) disable iff (!reset_n_i)
        s_global_read |=> rd_valid_o && !rd_data_o[7] && rd_data_o[6:0] == $past(global_q);
    endproperty
    a_global_top_zero: assert property (p_global_top_zero)
        else $error("global read data wrong");

    property p_por_clear;
        @(posedge mclk_i) disable iff (!reset_n_i)
        s_global_read |=> !global_q[FSR_BIT_POWER_ON] ##1 !global_q[FSR_BIT_POWER_ON];
    endproperty
    a_por_clear: assert property (p_por_clear) else $error("power-on flag not cleared");

    property p_die_ot;
        @(posedge mclk_i) disable iff (!reset_n_i)
        global_cond_i.die_overtemp |=> global_q[FSR_BIT_DIE_OT];
    endproperty
    a_die_ot: assert property (p_die_ot) else $error("die overtemp not latched");

    property p_link_err_hold;
        @(posedge mclk_i) disable iff (!reset_n_i)
        global_q[FSR_BIT_LINK_ERR] && !rd_global |=> global_q[FSR_BIT_LINK_ERR];
    endproperty
    a_link_err_hold: assert property (p_link_err_hold)
        else $error("link error lost without read");

    property p_wdt_persist;
        @(posedge mclk_i) disable iff (!reset_n_i)
        s_global_read ##0 global_cond_i.link_watchdog_expired |=> global_q[FSR_BIT_LINK_WDT];
    endproperty
    a_wdt_persist: assert property (p_wdt_persist)
        else $error("watchdog flag cleared early");

    property p_supply_flags;
        @(posedge mclk_i) disable iff (!reset_n_i)
        s_global_read ##0 !global_cond_i.logic_supply_low ##0 !global_cond_i.load_supply_warn
        ##0 !global_cond_i.load_supply_low
        |=> global_q[2:0] == 3'h0;
    endproperty
    a_supply_flags: assert property (p_supply_flags)
        else $error("supply flags not cleared");

    property p_short_clear;
        @(posedge mclk_i) disable iff (!reset_n_i)
        rd_short && chan_cond_i.short_to_supply_fault == 4'h0 |=> short_q == 4'h0;
    endproperty
    a_short_clear: assert property (p_short_clear)
        else $error("short flags not cleared");

    property p_open_set;
        @(posedge mclk_i) disable iff (!reset_n_i)
        chan_cond_i.open_wire_off_fault[3] |=> open_q[3] ##1 (open_q[3] || $past(rd_open));
    endproperty
    a_open_set: assert property (p_open_set) else $error("open wire ch4 not latched");

    property p_persist_keeps;
        @(posedge mclk_i) disable iff (!reset_n_i)
        rd_open && chan_cond_i.open_wire_off_fault[1] |=> open_q[1];
    endproperty
    a_persist_keeps: assert property (p_persist_keeps)
        else $error("persistent fault cleared");

    property p_summary_read;
        @(posedge mclk_i) disable iff (!reset_n_i)
        rd_req_i && rd_addr_i == FSR_OFS_CHAN_SUM |=> rd_data_o == $past(summary_q);
    endproperty
    a_summary_read: assert property (p_summary_read)
        else $error("summary read mismatch");

    property p_open_ch1_clear;
        @(posedge mclk_i) disable iff (!reset_n_i)
        rd_open && !chan_cond_i.open_wire_off_fault[0] |=> !open_q[0];
    endproperty
    a_open_ch1_clear: assert property (p_open_ch1_clear)
        else $error("open ch1 not cleared");

    property p_chan1_fall;
        @(posedge mclk_i) disable iff (!reset_n_i)
        s_chan1_clean |=> !summary_q[0];
    endproperty
    a_chan1_fall: assert property (p_chan1_fall) else $error("summary bit 0 stuck");

endmodule : fsr_fault_status

// File: fsr_host_model.sv
// Host-side read master model for the fault status bank
`timescale 1ns/1ps
module fsr_host_model
    import fsr_pkg::*;
(
    // Clock
    input  wire logic                  mclk_i,
    // Read request to the device
    output logic                       rd_req_o,
    output logic      [FSR_ADDR_W-1:0] rd_addr_o
);
    initial
    begin
        rd_req_o  = 1'b0;
        rd_addr_o = '0;
    end

    // Entered at a falling edge; request stands over one rising edge
    task automatic rd(input logic [FSR_ADDR_W-1:0] a);
        rd_req_o  = 1'b1;
        rd_addr_o = a;
        @(negedge mclk_i);
    endtask : rd

    // Idle offset is scrambled so a stale address is never relied on
    task automatic idle();
        rd_req_o  = 1'b0;
        rd_addr_o = FSR_ADDR_W'($urandom);
        @(negedge mclk_i);
    endtask : idle
endmodule : fsr_host_model

// File: tb_fsr_fault_status.sv
// Self-checking bench for the fault status register bank
`timescale 1ns/1ps
module tb_fsr_fault_status;
    import fsr_pkg::*;

    logic                  mclk      = 1'b0;
    logic                  reset_n_i = 1'b0;
    fsr_chan_cond_t        cc        = '0;
    fsr_global_cond_t      gc        = '0;
    logic                  rd_req;
    logic [FSR_ADDR_W-1:0] rd_addr;
    logic [FSR_DATA_W-1:0] rd_data;
    logic                  rd_valid;
    logic [FSR_DATA_W-1:0] summary;
    logic [FSR_DATA_W-1:0] exp_q[$];
    int                    fails       = 0;
    int                    checks_done = 0;
    logic [3:0]            m;

    always #5 mclk = ~mclk;

    fsr_host_model host (.mclk_i(mclk), .rd_req_o(rd_req), .rd_addr_o(rd_addr));

    fsr_fault_status #(.NUM_CHAN(4)) uut (
        .mclk_i(mclk), .reset_n_i(reset_n_i), .chan_cond_i(cc), .global_cond_i(gc),
        .rd_req_i(rd_req), .rd_addr_i(rd_addr), .rd_data_o(rd_data),
        .rd_valid_o(rd_valid), .chan_fault_summary_o(summary));

    task automatic compare(input string what, input logic [7:0] e, input logic [7:0] s);
        checks_done++;
        if (s !== e)
        begin
            fails++;
            $display("mismatch %s expected %h seen %h", what, e, s);
        end
    endtask : compare

    task automatic complete_run();
        if (exp_q.size() != 0)
        begin
            fails++;
            $display("mismatch rd_pending expected 0 seen %0d", exp_q.size());
        end
        if (fails == 0 && checks_done > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : complete_run

    // Each answer is one valid pulse; an unasked pulse is a fault too
    always @(negedge mclk)
        if (rd_valid === 1'b1)
        begin
            if (exp_q.size() == 0)
            begin
                fails++;
                $display("mismatch rd_valid expected 0 seen 1");
            end
            else
                compare("rd_data", exp_q.pop_front(), rd_data);
        end

    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        host.rd(a);
    endtask : rd

    task automatic idle();
        host.idle();
    endtask : idle

    task automatic do_reset();
        reset_n_i = 1'b0;
        repeat (20) @(negedge mclk);
        reset_n_i = 1'b1;
    endtask : do_reset

    // Read twice while live, drop cause, then clearing read and empty read
    task automatic sticky(input logic [3:0] a, input logic [7:0] v, input logic [7:0] s);
        compare("summary", s, summary);
        rd(a, v);
        rd(a, v);
        cc = '0;
        gc = '0;
        idle();
        rd(a, v);
        rd(a, 8'h00);
        idle();
        idle();
        compare("summary", 8'h00, summary);
    endtask : sticky

    initial
    begin
        #200000;
        fails++;
        complete_run();
    end

    initial
    begin
        void'($urandom(32'hf21c_b3d9));
        do_reset();
        for (int a = 0; a < 16; a++)
            rd(4'(a), (a == 2) ? FSR_RST_GLOBAL : 8'h00);
        rd(FSR_OFS_GLOBAL, 8'h00);
        idle();
        for (int i = 0; i < 6; i++)
        begin
            m  = 4'($urandom) | 4'h1;
            cc = fsr_chan_cond_t'(24'(m) << (4 * i));
            idle();
            idle();
            if (i < 2)
                sticky((i == 0) ? FSR_OFS_SHORT : FSR_OFS_OPEN_OFF, 8'(m), 8'(m));
            else
            begin
                compare("summary", 8'(m), summary);
                rd(FSR_OFS_CHAN_SUM, 8'(m));
                cc = '0;
                idle();
                idle();
                compare("summary", 8'h00, summary);
            end
        end
        for (int i = 0; i < 6; i++)
        begin
            gc = fsr_global_cond_t'(6'h01 << i);
            idle();
            idle();
            sticky(FSR_OFS_GLOBAL, 8'h01 << i, 8'h00);
        end
        do_reset();
        rd(FSR_OFS_GLOBAL, FSR_RST_GLOBAL);
        rd(FSR_OFS_GLOBAL, 8'h00);
        idle();
        idle();
        complete_run();
    end
endmodule : tb_fsr_fault_status
